/* File: design/scp_sync.sv */
// Package of shared constants and the two-flop level synchroniser
`timescale 1ns/1ps
package scp_pkg;
	localparam int          FRAME_BITS  = 16;
	localparam int          ADDR_W      = 7;
	localparam int          DATA_W      = 8;
	localparam int          REG_COUNT   = 128;
	localparam logic [3:0]  CNT_LAST    = 4'hf;
	localparam logic [3:0]  CNT_RD_LAST = 4'h8;
	localparam int          POS_RW      = 15;
	localparam int          POS_ADDR    = 8;
	localparam logic [7:0]  REG_RESET   = 8'h00;
	localparam logic [6:0]  ADDR_INPUT  = 7'h34;
	localparam logic [6:0]  ADDR_DIFF   = 7'h38;
	localparam logic [6:0]  ADDR_OUTCFG = 7'h64;
	localparam logic [7:0]  MASK_INPUT  = 8'h04;
	localparam logic [7:0]  MASK_DIFF   = 8'h60;
	localparam logic [7:0]  MASK_OUTCFG = 8'h10;
	localparam int          BIT_INPUT   = 2;
	localparam int          BIT_DIFF_LO = 5;
	localparam int          BIT_DIFF_HI = 6;
	localparam int          BIT_OUTCFG  = 4;
endpackage

module scp_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic d_in,
	output logic      q_out
);
	logic meta_q;

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			meta_q <= RST_VAL;
			q_out  <= RST_VAL;
		end else begin
			meta_q <= d_in;
			q_out  <= meta_q;
		end
	end
endmodule

/* File: design/scp_top.sv */
// Serial configuration port with master reset and rate strap defaults
//
// Overview of operation
// R01 - Host holds chip select low during access
// R02 - Capture serial input on rising clock edge
// R03 - Edge select high makes falling edge active
// R04 - Read data returned on serial output line
// R05 - Master reset low restores all defaults
// R06 - Rate strap sets network rate bits
// R07 - Software may overwrite strap rate bits
// R08 - Registers hold eight bits, hex addressed
// R09 - Deselected port ignores clock, output inactive
`timescale 1ns/1ps
module scp_top (
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	input  wire logic master_reset_low_in,
	input  wire logic rate_select_in,
	input  wire logic chip_select_low_in,
	input  wire logic sclk_in,
	input  wire logic sdi_in,
	input  wire logic clock_edge_select_in,
	output logic      sdo_out,
	output logic      sdo_oe_out,
	output logic      sonet_input_out,
	output logic [1:0] sonet_diff_out,
	output logic      sonet_outcfg_out
);
	localparam int RC = scp_pkg::REG_COUNT;

	// Link domain
	logic        link_clk;
	logic [3:0]  cnt_q;
	logic [14:0] sh_q;
	logic [15:0] word_q;
	logic        tog_q;
	logic        sdo_q;
	logic        oe_q;
	logic [3:0]  rd_idx;

	// Reference domain
	logic        mrst_s;
	logic        strap_s;
	logic        tog_s;
	logic        tog_seen_q;
	logic        do_reset;
	logic        new_frame;
	logic        word_rw;
	logic [6:0]  word_addr;
	logic [7:0]  word_data;
	logic [7:0]  regs_q [RC];
	logic [7:0]  reg_def [RC];
	logic [7:0]  rd_mux;
	logic [7:0]  rd_hold_q;

	// R03 clock edge select
	assign link_clk = sclk_in ^ clock_edge_select_in;
	assign rd_idx   = 4'(scp_pkg::CNT_RD_LAST - cnt_q - 4'h1);

	// R09 deselect clears frame
	// R02 shift in serial data
	always_ff @(posedge link_clk or posedge chip_select_low_in) begin
		if (chip_select_low_in) begin
			cnt_q <= 4'h0;
			sh_q  <= 15'h0000;
			sdo_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			cnt_q <= 4'(cnt_q + 4'h1);
			sh_q  <= {sh_q[13:0], sdi_in};
			oe_q  <= 1'b1;
			// R04 read data out
			sdo_q <= (cnt_q < scp_pkg::CNT_RD_LAST) ? rd_hold_q[rd_idx[2:0]] : 1'b0;
		end
	end

	// Frame word handed over by toggle
	always_ff @(posedge link_clk or negedge master_reset_low_in) begin
		if (!master_reset_low_in) begin
			word_q <= 16'h0000;
			tog_q  <= 1'b0;
		end else if (!chip_select_low_in && cnt_q == scp_pkg::CNT_LAST) begin
			word_q <= {sh_q, sdi_in};
			tog_q  <= ~tog_q;
		end
	end

	assign sdo_out    = sdo_q;
	assign sdo_oe_out = oe_q;

	scp_sync #(.RST_VAL(1'b1)) u_mrst (
		.clk_in   (ref_clk_in),
		.rst_n_in (rst_n_in),
		.d_in     (master_reset_low_in),
		.q_out    (mrst_s)
	);
	// Free-running so reset loads the live strap
	scp_sync #(.RST_VAL(1'b0)) u_strap (
		.clk_in   (ref_clk_in),
		.rst_n_in (1'b1),
		.d_in     (rate_select_in),
		.q_out    (strap_s)
	);
	scp_sync #(.RST_VAL(1'b0)) u_tog (
		.clk_in   (ref_clk_in),
		.rst_n_in (mrst_s),
		.d_in     (tog_q),
		.q_out    (tog_s)
	);

	// R05 master reset
	assign do_reset  = !rst_n_in || !mrst_s;
	assign new_frame = tog_s ^ tog_seen_q;
	assign word_rw   = word_q[scp_pkg::POS_RW];
	assign word_addr = word_q[scp_pkg::POS_RW-1:scp_pkg::POS_ADDR];
	assign word_data = word_q[scp_pkg::DATA_W-1:0];
	assign rd_mux    = regs_q[word_addr];

	always_ff @(posedge ref_clk_in) begin
		if (do_reset) begin
			// Track toggle so no stale frame follows reset
			tog_seen_q <= tog_s;
			rd_hold_q  <= scp_pkg::REG_RESET;
		end else begin
			tog_seen_q <= tog_s;
			// R04 latch read data
			if (new_frame && word_rw) begin
				rd_hold_q <= rd_mux;
			end
		end
	end

	// R08 eight-bit registers
	for (genvar i = 0; i < RC; i++) begin : g_reg
		localparam logic [7:0] MASK =
			(i == int'(scp_pkg::ADDR_INPUT))  ? scp_pkg::MASK_INPUT :
			(i == int'(scp_pkg::ADDR_DIFF))   ? scp_pkg::MASK_DIFF :
			(i == int'(scp_pkg::ADDR_OUTCFG)) ? scp_pkg::MASK_OUTCFG : 8'h00;
		// R06 strap sets rate bits
		assign reg_def[i] = scp_pkg::REG_RESET | (strap_s ? MASK : 8'h00);
		always_ff @(posedge ref_clk_in) begin
			if (do_reset) begin
				regs_q[i] <= reg_def[i];
			// R07 software overwrite
			end else if (new_frame && !word_rw && word_addr == 7'(i)) begin
				regs_q[i] <= word_data;
			end
		end
	end

	assign sonet_input_out  = regs_q[scp_pkg::ADDR_INPUT][scp_pkg::BIT_INPUT];
	assign sonet_diff_out   =
		regs_q[scp_pkg::ADDR_DIFF][scp_pkg::BIT_DIFF_HI:scp_pkg::BIT_DIFF_LO];
	assign sonet_outcfg_out = regs_q[scp_pkg::ADDR_OUTCFG][scp_pkg::BIT_OUTCFG];

	// Checks in the reference domain
	AST_STRAP_DEFAULT: assert property (@(posedge ref_clk_in) // R06
		do_reset && $past(do_reset, 2) |=> sonet_input_out == $past(strap_s)
			&& sonet_diff_out == {2{$past(strap_s)}}
			&& sonet_outcfg_out == $past(strap_s))
		else $error("Strap default not loaded");
	AST_MASTER_RESET: assert property (@(posedge ref_clk_in) // R05
		!mrst_s |=> regs_q[0] == scp_pkg::REG_RESET && rd_hold_q == scp_pkg::REG_RESET
			&& !tog_seen_q)
		else $error("Master reset left state");
	AST_SW_OVERWRITE: assert property (@(posedge ref_clk_in) disable iff (do_reset) // R07
		new_frame && !word_rw && word_addr == scp_pkg::ADDR_INPUT
			|=> sonet_input_out == $past(word_data[scp_pkg::BIT_INPUT]))
		else $error("Rate bit write lost");
	AST_OTHER_STABLE: assert property (@(posedge ref_clk_in) disable iff (do_reset) // R08
		new_frame && word_addr != scp_pkg::ADDR_DIFF ##1 !do_reset |-> $stable(sonet_diff_out))
		else $error("Unaddressed register changed");
	AST_READ_HOLD: assert property (@(posedge ref_clk_in) disable iff (do_reset) // R04
		new_frame && word_rw |=> rd_hold_q == $past(rd_mux))
		else $error("Read data not held");
	AST_CS_IDLE: assert property (@(posedge ref_clk_in) // R09
		chip_select_low_in |-> !sdo_oe_out && !sdo_out)
		else $error("Serial output active while deselected");
	AST_DEFAULT_ZERO: assert property (@(posedge ref_clk_in) // R05
		do_reset |=> (regs_q[scp_pkg::ADDR_INPUT] & ~scp_pkg::MASK_INPUT) == scp_pkg::REG_RESET
			&& (regs_q[scp_pkg::ADDR_DIFF] & ~scp_pkg::MASK_DIFF) == scp_pkg::REG_RESET
			&& regs_q[RC-1] == scp_pkg::REG_RESET)
		else $error("Register default not restored");
	AST_WRITE_DATA: assert property (@(posedge ref_clk_in) disable iff (do_reset) // R08
		new_frame && !word_rw
			|=> regs_q[$past(word_addr)] == $past(word_data))
		else $error("Register write not applied");
	// Register outputs move only on a frame or a reset
	AST_NO_SPURIOUS: assert property (@(posedge ref_clk_in) // R09
		!new_frame && !do_reset |=> $stable(sonet_input_out)
			&& $stable(sonet_diff_out) && $stable(sonet_outcfg_out))
		else $error("Register changed without a frame");
	AST_HOLD_IDLE: assert property (@(posedge ref_clk_in) // R04
		!(new_frame && word_rw) && !do_reset |=> $stable(rd_hold_q))
		else $error("Read byte changed without a read");

	// Checks in the link domain
	AST_CAPTURE: assert property (@(posedge link_clk) disable iff (chip_select_low_in) // R02
		cnt_q != 4'h0 |-> sh_q[0] == $past(sdi_in))
		else $error("Serial bit not captured");
	// Falling link edge sees the result of the active edge
	AST_FRAME_END: assert property (@(negedge link_clk) disable iff (chip_select_low_in) // R02
		cnt_q == 4'h0 |-> tog_q != $past(tog_q)
			&& word_q == {$past(sh_q), sdi_in})
		else $error("Frame end not handed over");
	AST_OE_ACTIVE: assert property (@(negedge link_clk) disable iff (chip_select_low_in) // R04
		sdo_oe_out)
		else $error("Serial output not enabled in frame");
	AST_SDO_BIT: assert property (@(posedge link_clk) disable iff (chip_select_low_in) // R04
		cnt_q >= 4'h1 && cnt_q <= scp_pkg::CNT_RD_LAST
			|-> sdo_q == rd_hold_q[3'(scp_pkg::CNT_RD_LAST - cnt_q)])
		else $error("Serial output bit wrong");
	AST_SDO_TAIL: assert property (@(posedge link_clk) disable iff (chip_select_low_in) // R04
		cnt_q > scp_pkg::CNT_RD_LAST |-> !sdo_q)
		else $error("Serial output not idle after read byte");

	COV_WRITE: cover property (@(posedge ref_clk_in) new_frame && !word_rw && !do_reset);
	COV_READ: cover property (@(posedge ref_clk_in) new_frame && word_rw && !do_reset);
	COV_MRST: cover property (@(posedge ref_clk_in) rst_n_in && !mrst_s);
	COV_SONET: cover property (@(posedge ref_clk_in) do_reset && strap_s);
	COV_EDGE_FALL: cover property (@(posedge ref_clk_in) new_frame && clock_edge_select_in && !do_reset);
endmodule

/* File: tb/scp_host.sv */
// Host model that drives serial configuration frames
`timescale 1ns/1ps
module scp_host (
	input  wire logic edge_sel_in,
	input  wire logic sdo_in,
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      sdi_out
);
	logic ph;

	// Clock stands still between frames
	assign sclk_out = ph ^ edge_sel_in;

	initial begin
		ph = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
	end

	task automatic frame(input logic [15:0] w, output logic [7:0] rd);
		cs_n_out = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi_out = w[i];
			#7.5;
			if (i <= 14 && i >= 7) begin
				rd[i - 7] = sdo_in;
			end
			ph = 1'b1;
			#7.5;
			ph = 1'b0;
		end
		#7.5;
		cs_n_out = 1'b1;
		// Data line pulled low once released
		sdi_out = 1'b0;
	endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the serial configuration port
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
	logic       clk, rst_n, mrst_n, strap, edge_sel, cs_n, sclk, sdi, sdo, sdo_oe, s_in, s_oc;
	logic [1:0] s_diff;
	logic [7:0] rd;
	int         fail_count = 0;
	int         n_compared = 0;

	scp_top i_dut (
		.ref_clk_in           (clk),
		.rst_n_in             (rst_n),
		.master_reset_low_in  (mrst_n),
		.rate_select_in       (strap),
		.chip_select_low_in   (cs_n),
		.sclk_in              (sclk),
		.sdi_in               (sdi),
		.clock_edge_select_in (edge_sel),
		.sdo_out              (sdo),
		.sdo_oe_out           (sdo_oe),
		.sonet_input_out      (s_in),
		.sonet_diff_out       (s_diff),
		.sonet_outcfg_out     (s_oc)
	);

	scp_host i_host (
		.edge_sel_in (edge_sel),
		.sdo_in      (sdo),
		.cs_n_out    (cs_n),
		.sclk_out    (sclk),
		.sdi_out     (sdi)
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic xfer(input logic [15:0] w);
		i_host.frame(w, rd);
		cyc(6);
	endtask

	task automatic stop_test();
		$display("compared=%0d failures=%0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	initial begin
		#200000;
		fail_count++;
		stop_test();
	end

	initial begin
		rst_n = 1'b0;
		mrst_n = 1'b0;
		strap = 1'b1;
		edge_sel = 1'b0;
		cyc(4);
		rst_n = 1'b1;
		mrst_n = 1'b1;
		cyc(4);
		`CHK({s_in, s_diff, s_oc}, 4'hf)
		`CHK(sdo_oe, 1'b0)
		xfer(16'h3400);
		`CHK(s_in, 1'b0)
		xfer(16'h3840);
		`CHK(s_diff, 2'h2)
		xfer(16'hb800);
		xfer(16'hb800);
		`CHK(rd, 8'h40)
		edge_sel = 1'b1;
		cyc(2);
		xfer(16'h64a5);
		`CHK(s_oc, 1'b0)
		xfer(16'he400);
		xfer(16'he400);
		`CHK(rd, 8'ha5)
		`CHK(sdo_oe, 1'b0)
		strap = 1'b0;
		mrst_n = 1'b0;
		cyc(5);
		mrst_n = 1'b1;
		cyc(4);
		`CHK({s_in, s_diff, s_oc}, 4'h0)
		xfer(16'he400);
		xfer(16'he400);
		`CHK(rd, 8'h00)
		stop_test();
	end
endmodule
